// file: verification/coprocessor_normal_dma_test.sv
// Self-checking bench for the normal-mode copy engine
`timescale 1ns/1ps
`default_nettype none
module coprocessor_normal_dma_test;
  import ndma_pkg::*;
  logic clock, resetn, reg_write, reg_read, flag_clear, host_access;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, mem_rd_data, mem_wr_data, d;
  logic [1:0]  mem_rd_sel;
  logic [23:0] mem_rd_addr, mem_wr_addr;
  logic        mem_rd, mem_wr_sel, mem_wr, cpu_stall, cpu_irq, conversion_mode;
  int          fails = 0, n_tests = 0, fast_gap = 0;
  // Copies: control, source, destination, count, stall expected, host busy
  logic [7:0]  t_ctl[6] = '{8'h80, 8'hc4, 8'hc1, 8'h86, 8'hc0, 8'hc6};
  logic [23:0] t_src[6] = '{24'h123456, 24'h0a0010, 24'h420100, 24'hfff7f0, 24'h000200, 24'h000020};
  logic [23:0] t_dst[6] = '{24'h00f1f0, 24'h41fff0, 24'h000300, 24'h430000, 24'h000010, 24'h400040};
  logic [15:0] t_cnt[6] = '{16'h3, 16'h2, 16'h4, 16'h3, 16'h5, 16'h2};
  logic        t_stl[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic        t_hst[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  ndma_engine #(.pace_width(4)) uut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .flag_clear(flag_clear), .mem_rd_sel(mem_rd_sel), .mem_rd_addr(mem_rd_addr),
    .mem_rd(mem_rd), .mem_rd_data(mem_rd_data), .mem_wr_sel(mem_wr_sel),
    .mem_wr_addr(mem_wr_addr), .mem_wr(mem_wr), .mem_wr_data(mem_wr_data),
    .host_access(host_access), .cpu_stall(cpu_stall), .cpu_irq(cpu_irq),
    .conversion_mode(conversion_mode));
  ndma_mem_model mem (.clock(clock), .mem_rd_sel(mem_rd_sel), .mem_rd_addr(mem_rd_addr),
    .mem_rd(mem_rd), .mem_rd_data(mem_rd_data), .mem_wr_sel(mem_wr_sel),
    .mem_wr_addr(mem_wr_addr), .mem_wr(mem_wr), .mem_wr_data(mem_wr_data));
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One register byte write: strobe for a single cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd_flags(output logic [7:0] v);
    @(posedge clock);
    reg_addr <= coprocessor_flags_addr;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic run(input int k);
    int n, i, g, first;
    logic [23:0] sm, dm;
    logic stall;
    sm = t_ctl[k][1:0] == src_rom ? 24'hffffff : t_ctl[k][1:0] == src_bwr ? 24'h3ffff : 24'h7ff;
    dm = t_ctl[k][dest_select_bit] ? 24'h3ffff : 24'h7ff;
    wr(dma_control_addr, t_ctl[k]);
    wr(dma_src_addr_lo, t_src[k][7:0]);
    wr(dma_src_addr_mid, t_src[k][15:8]);
    wr(dma_src_addr_hi, t_src[k][23:16]);
    wr(dma_count_lo, t_cnt[k][7:0]);
    wr(dma_count_hi, t_cnt[k][15:8]);
    wr(dma_dst_addr_lo, t_dst[k][7:0]);
    wr(dma_dst_addr_mid, t_dst[k][15:8]);
    if (t_ctl[k][dest_select_bit])
      wr(dma_dst_addr_hi, t_dst[k][23:16]);
    stall = 1'b0;
    g = 0;
    first = -1;
    // Host grabs memory for the first cycles where asked
    for (n = 0; n < 500 && cpu_irq !== 1'b1; n++) begin
      @(posedge clock);
      host_access <= t_hst[k] && n < 12;
      #1;
      stall |= cpu_stall === 1'b1;
      if (mem_rd === 1'b1) begin
        if (first >= 0 && g == 0)
          g = n - first;
        first = n;
      end
    end
    check(40'(n < 500), 40'h1);
    check(40'(stall), 40'(t_stl[k]));
    check(40'(mem.wlog.size()), 40'(t_cnt[k]));
    for (i = 0; i < t_cnt[k] && mem.wlog.size() > 0; i++)
      check(40'(mem.wlog.pop_front()), 40'({t_ctl[k][dest_select_bit], (t_dst[k] + 24'(i)) & dm,
        mem.src_byte(t_ctl[k][1:0], (t_src[k] + 24'(i)) & sm)}));
    if (k == 0)
      fast_gap = g;
    else if (!t_hst[k])
      check(40'(g), 40'(fast_gap + slow_cycles - fast_cycles));
    rd_flags(d);
    check(40'(d[done_flag_bit]), 40'h1);
    @(posedge clock);
    flag_clear <= 1'b1;
    @(posedge clock);
    flag_clear <= 1'b0;
    rd_flags(d);
    check(40'(d[done_flag_bit]), 40'h0);
    wr(dma_control_addr, 8'h00);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    fails++;
    end_of_test();
  end
  initial begin
    {resetn, reg_write, reg_read, flag_clear, host_access} = 5'h0;
    reg_addr = 16'h0;
    reg_wdata = 8'h0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    for (int k = 0; k < 6; k++)
      run(k);
    // Conversion mode or no enable: a trigger must start nothing
    foreach (t_ctl[j]) if (j < 2) begin
      wr(dma_control_addr, j == 0 ? 8'ha0 : 8'h00);
      #1 check(40'(conversion_mode), 40'(j == 0));
      wr(dma_count_lo, 8'h02);
      wr(dma_dst_addr_lo, 8'h10);
      wr(dma_dst_addr_mid, 8'h00);
      repeat (20) @(posedge clock);
      check(40'(mem.wlog.size()), 40'h0);
    end
    end_of_test();
  end
endmodule
bind ndma_engine ndma_engine_chk chk (.clock(clock), .resetn(resetn), .mem_rd_sel(mem_rd_sel),
  .mem_rd_addr(mem_rd_addr), .mem_rd(mem_rd), .mem_wr_sel(mem_wr_sel), .mem_wr_addr(mem_wr_addr),
  .mem_wr(mem_wr), .host_access(host_access), .cpu_stall(cpu_stall), .cpu_irq(cpu_irq));
`default_nettype wire

// file: verification/ndma_engine_chk.sv
// Concurrent checks on the copy engine's memory strobes and status
`timescale 1ns/1ps
`default_nettype none
module ndma_engine_chk
  import ndma_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // Memory side
  input wire logic [1:0]  mem_rd_sel,
  input wire logic [23:0] mem_rd_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr_sel,
  input wire logic [23:0] mem_wr_addr,
  input wire logic        mem_wr,
  // Host and status
  input wire logic        host_access,
  input wire logic        cpu_stall,
  input wire logic        cpu_irq
);
  logic [23:0] rd_last, wr_last;
  logic        rd_seen, wr_seen;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Last strobe addresses of one copy; forgotten at completion
  always_ff @(posedge clock) begin
    rd_seen <= resetn && !cpu_irq && (rd_seen || mem_rd);
    wr_seen <= resetn && !cpu_irq && (wr_seen || mem_wr);
    rd_last <= mem_rd ? mem_rd_addr : rd_last;
    wr_last <= mem_wr ? mem_wr_addr : wr_last;
  end
  a_rd_then_wr: assert property (mem_rd |=> mem_wr)
    else $error("write did not follow read");
  a_wr_needs_rd: assert property (mem_wr |-> $past(mem_rd))
    else $error("write without read");
  a_rd_addr_step: assert property (mem_rd && rd_seen |-> mem_rd_addr == rd_last + 24'h1)
    else $error("source address did not step by one");
  a_wr_addr_step: assert property (mem_wr && wr_seen |-> mem_wr_addr == wr_last + 24'h1)
    else $error("destination address did not step by one");
  a_irq_after_wr: assert property (cpu_irq |-> $past(mem_wr))
    else $error("completion without final write");
  a_irq_ends_copy: assert property (cpu_irq |=> !cpu_irq && !mem_rd)
    else $error("completion pulse too long or copy went on");
  a_host_wait: assert property (host_access [*4] |-> !mem_rd && !mem_wr)
    else $error("memory touched during host access");
  a_rd_spacing: assert property (mem_rd |=> !mem_rd [*2])
    else $error("reads too close together");
  a_src_width: assert property (mem_rd |-> (mem_rd_sel == src_rom) ||
    (mem_rd_sel == src_bwr && mem_rd_addr[23:18] == 6'h0) ||
    (mem_rd_sel == src_iram && mem_rd_addr[23:11] == 13'h0))
    else $error("bad source select or width");
  a_dst_width: assert property (mem_wr |->
    ((mem_wr_sel ? (mem_wr_addr >> 18) : (mem_wr_addr >> 11)) == 24'h0))
    else $error("destination wider than its memory");
  a_stall_pair: assert property (cpu_stall && mem_wr |->
    (mem_rd_sel == src_bwr && mem_wr_sel == dst_iram) ||
    (mem_rd_sel == src_iram && mem_wr_sel == dst_bwr))
    else $error("stall on a pairing that ignores priority");
  c_done: cover property (cpu_irq);
  c_stall: cover property (cpu_stall && mem_wr);
  c_host: cover property (host_access [*4]);
endmodule
`default_nettype wire

// file: verification/ndma_mem_model.sv
// Behavioural ROM, backup RAM and internal RAM behind the copy engine
`timescale 1ns/1ps
`default_nettype none
module ndma_mem_model (
  // Clock
  input  wire logic        clock,
  // Read side
  input  wire logic [1:0]  mem_rd_sel,
  input  wire logic [23:0] mem_rd_addr,
  input  wire logic        mem_rd,
  output logic [7:0]       mem_rd_data,
  // Write side
  input  wire logic        mem_wr_sel,
  input  wire logic [23:0] mem_wr_addr,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wr_data
);
  logic [32:0] wlog[$];
  initial mem_rd_data = 8'h5a;
  // Pattern differs per memory, so a wrong source is caught
  function automatic logic [7:0] src_byte(logic [1:0] s, logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ {s, 6'h2b};
  endfunction
  // Answer within the strobe's own cycle, at the falling edge; toggles otherwise
  always @(negedge clock)
    mem_rd_data <= mem_rd ? src_byte(mem_rd_sel, mem_rd_addr) : ~mem_rd_data;
  // Log every destination write for the bench to compare
  always @(posedge clock)
    if (mem_wr)
      wlog.push_back({mem_wr_sel, mem_wr_addr, mem_wr_data});
endmodule
`default_nettype wire

// file: verilog/ndma_engine.sv
// Normal-mode memory copy engine of the cartridge coprocessor
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Source select: 00 ROM, 01 backup work RAM, 10 internal RAM.
// - Destination select: 0 internal RAM, 1 backup work RAM.
// - Conversion mode 0 means plain copy; 1 hands off to conversion logic.
// - Bit 6 priority: 0 CPU keeps bus, 1 engine stalls the CPU.
// - Priority bit only applies to backup RAM and internal RAM pairings.
// - Enable set clears parameters; clear disables; software sequences it.
// - Source width 24 bits ROM, 18 backup RAM, 11 internal RAM.
// - Sixteen-bit byte count 1 to 65535 loads the terminal counter.
// - Writing 2237H (backup RAM) or 2236H (internal RAM) starts the copy.
// - The copy ends when the terminal counter reaches zero.
// - Completion raises a CPU interrupt and sets the done flag.
// - ROM to internal RAM at full rate; other pairings at half rate. Here each byte takes 3 cycles and 4 cycles respectively.
// - Host console memory access makes the engine wait.
module ndma_engine
  import ndma_pkg::*;
#(
  parameter int pace_width = 4
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Coprocessor CPU register port
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  input  wire logic        flag_clear,
  // Memory side
  output logic [1:0]       mem_rd_sel,
  output logic [23:0]      mem_rd_addr,
  output logic             mem_rd,
  input  wire logic [7:0]  mem_rd_data,
  output logic             mem_wr_sel,
  output logic [23:0]      mem_wr_addr,
  output logic             mem_wr,
  output logic [7:0]       mem_wr_data,
  // Host console access in progress
  input  wire logic        host_access,
  // Status toward the coprocessor CPU
  output logic             cpu_stall,
  output logic             cpu_irq,
  output logic             conversion_mode
);
  // Elaboration checks: the pacer must hold both rate periods
  if (pace_width < 2) begin : g_width_check
    $error("pace_width too small");
  end
  if (fast_cycles < 1 || slow_cycles < 1) begin : g_rate_check
    $error("rate periods must be at least one cycle");
  end
  if (slow_cycles >= (1 << pace_width)) begin : g_period_check
    $error("pace_width cannot hold the slow period");
  end
  // Address padding below assumes these memory widths
  if (rom_addr_bits != 24 || bwr_addr_bits != 18 || iram_addr_bits != 11) begin : g_addr
    $error("memory address widths differ from the padding logic");
  end

  // All engine state in one record; every output is a field of it
  typedef struct packed {
    eng_state_e  fsm;
    logic [7:0]  control;
    logic [23:0] src;
    logic [23:0] dst;
    logic [15:0] count;
    logic [15:0] term;
    logic        done_flag;
    logic [7:0]  rdata;
    logic [1:0]  rd_sel;
    logic [23:0] rd_addr;
    logic        rd;
    logic        wr_sel;
    logic [23:0] wr_addr;
    logic        wr;
    logic [7:0]  wr_data;
    logic        stall;
    logic        irq;
  } engine_s;

  engine_s state;
  engine_s next_state;

  logic [1:0]            source_select;
  logic                  dest_select;
  logic                  pace_run;
  logic                  pace_tick;
  logic [pace_width-1:0] pace_period;
  logic                  bwr_iram_pair;
  logic [23:0]           src_masked;
  // Decoded helpers for the sequencing logic
  logic [23:0]           dst_masked;
  logic                  control_hit;
  logic                  enable_rise;
  logic                  abort_req;
  logic                  busy;
  logic                  trigger_hit;
  logic                  read_go;
  logic                  last_byte;
  logic                  priority_copy;
  logic                  flags_read;

  // Field decode of the control register
  assign source_select = state.control[src_sel_lsb +: 2];
  assign dest_select   = state.control[dest_select_bit];
  assign bwr_iram_pair = (source_select == src_bwr && dest_select == dst_iram)
                      || (source_select == src_iram && dest_select == dst_bwr);

  // Rate per pairing; same-device pairings are illegal and simply run slow
  always_comb begin
    case ({source_select, dest_select})
      {src_rom, dst_iram}: pace_period = pace_width'(fast_cycles);
      {src_rom, dst_bwr}:  pace_period = pace_width'(slow_cycles);
      {src_bwr, dst_iram}: pace_period = pace_width'(slow_cycles);
      {src_iram, dst_bwr}: pace_period = pace_width'(slow_cycles);
      default:             pace_period = pace_width'(slow_cycles);
    endcase
  end
  // Pacer reloads its period and restarts while the host owns memory
  assign pace_run = (state.fsm == st_read) && !host_access;

  // Unused upper source bits are dropped per memory
  always_comb begin
    case (source_select)
      src_rom:  src_masked = state.src;
      src_bwr:  src_masked = {6'h00, state.src[bwr_addr_bits-1:0]};
      src_iram: src_masked = {13'h0000, state.src[iram_addr_bits-1:0]};
      default:  src_masked = state.src;
    endcase
  end

  // Destination keeps only the bits its memory decodes
  always_comb begin
    if (dest_select == dst_bwr) begin
      dst_masked = {6'h00, state.dst[bwr_addr_bits-1:0]};
    end else begin
      dst_masked = {13'h0000, state.dst[iram_addr_bits-1:0]};
    end
  end

  // Register port decode shared by the sequencing logic
  assign control_hit   = reg_write && (reg_addr == dma_control_addr);
  // Parameters clear only on the enable edge, so a rewrite keeps them
  assign enable_rise   = control_hit && reg_wdata[transfer_en_bit]
                      && !state.control[transfer_en_bit];
  // Dropping enable abandons a running copy at once
  assign abort_req     = control_hit && !reg_wdata[transfer_en_bit];
  assign busy          = (state.fsm != st_idle);
  // Trigger byte follows the destination; ignored while busy or converting
  assign trigger_hit   = reg_write && state.control[transfer_en_bit]
                      && !state.control[conv_mode_bit] && !busy
                      && ((reg_addr == dma_dst_addr_hi && dest_select == dst_bwr)
                       || (reg_addr == dma_dst_addr_mid && dest_select == dst_iram));
  // A tick seen while the host holds memory is dropped; the pacer reloads
  assign read_go       = pace_tick && !host_access;
  assign last_byte     = (state.term == 16'h0001);
  // CPU yields only for priority copies between the two RAMs
  assign priority_copy = state.control[bus_priority_bit] && bwr_iram_pair;
  // Only the flag register reads back; every other address returns zero
  assign flags_read    = reg_read && (reg_addr == coprocessor_flags_addr);

  // One pacer serves every pairing; its period follows the control register
  ndma_pacer #(
    .width (pace_width)
  ) pacer (
    .clock  (clock),
    .resetn (resetn),
    .run    (pace_run),
    .period (pace_period),
    .tick   (pace_tick)
  );

  // Register writes, copy sequencing and flag handling
  always_comb begin
    next_state    = state;
    next_state.rd = 1'b0;
    next_state.wr = 1'b0;
    next_state.irq = 1'b0;

    // Register writes from the coprocessor CPU
    if (reg_write) begin
      case (reg_addr)
        dma_control_addr: begin
          next_state.control = reg_wdata;
          if (enable_rise) begin
            next_state.src   = addr_reset;
            next_state.dst   = addr_reset;
            next_state.count = count_reset;
          end
        end
        // Address and count bytes, least significant first
        dma_src_addr_lo:  next_state.src[7:0]   = reg_wdata;
        dma_src_addr_mid: next_state.src[15:8]  = reg_wdata;
        dma_src_addr_hi:  next_state.src[23:16] = reg_wdata;
        dma_dst_addr_lo:  next_state.dst[7:0]   = reg_wdata;
        dma_dst_addr_mid: next_state.dst[15:8]  = reg_wdata;
        dma_dst_addr_hi:  next_state.dst[23:16] = reg_wdata;
        dma_count_lo:     next_state.count[7:0]  = reg_wdata;
        dma_count_hi:     next_state.count[15:8] = reg_wdata;
        default: ;
      endcase
      // Zero count is outside the legal range; finish at once, not after 64K bytes
      if (trigger_hit) begin
        next_state.term = state.count;
        next_state.fsm  = (state.count == count_reset) ? st_done : st_read;
      end
    end

    case (state.fsm)
      // Waiting for a trigger byte
      st_idle: ;
      // Waiting for the pacer, then one source read
      st_read: begin
        if (read_go) begin
          next_state.rd      = 1'b1;
          next_state.rd_sel  = source_select;
          next_state.rd_addr = src_masked;
          next_state.fsm     = st_write;
        end
      end
      st_write: begin
        // Source answers while its read strobe stands; capture and pass it on
        next_state.wr      = 1'b1;
        next_state.wr_sel  = dest_select;
        next_state.wr_addr = dst_masked;
        next_state.wr_data = mem_rd_data;
        next_state.src     = state.src + 24'h000001;
        next_state.dst     = state.dst + 24'h000001;
        next_state.term    = state.term - 16'h0001;
        next_state.fsm     = last_byte ? st_done : st_read;
      end
      // One-cycle completion step
      st_done: begin
        next_state.irq       = 1'b1;
        next_state.done_flag = 1'b1;
        next_state.fsm       = st_idle;
      end
      default: next_state.fsm = st_idle;
    endcase

    // Disable wins over sequencing, so no strobe follows it
    if (abort_req) begin
      next_state.fsm = st_idle;
      next_state.rd  = 1'b0;
      next_state.wr  = 1'b0;
    end

    // Set beats clear when both land together
    if (flag_clear && state.fsm != st_done) begin
      next_state.done_flag = 1'b0;
    end

    // Stall the CPU only for priority copies between the two RAMs
    next_state.stall = (next_state.fsm == st_read || next_state.fsm == st_write)
                     && priority_copy;

    // Registered read data; control registers read as zero
    next_state.rdata = 8'h00;
    if (flags_read) begin
      next_state.rdata[done_flag_bit] = next_state.done_flag;
    end
  end

  // Synchronous reset; idle needs its one-hot code, not all zeros
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state         <= '0;
      state.fsm     <= st_idle;
      state.control <= control_reset;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register: register port
  assign reg_rdata       = state.rdata;

  // Source side
  assign mem_rd_sel      = state.rd_sel;
  assign mem_rd_addr     = state.rd_addr;
  assign mem_rd          = state.rd;

  // Destination side
  assign mem_wr_sel      = state.wr_sel;
  assign mem_wr_addr     = state.wr_addr;
  assign mem_wr          = state.wr;
  assign mem_wr_data     = state.wr_data;

  // Status toward the coprocessor CPU
  assign cpu_stall       = state.stall;
  assign cpu_irq         = state.irq;
  assign conversion_mode = state.control[conv_mode_bit];
endmodule
`default_nettype wire

// file: verilog/ndma_pacer.sv
// Byte pacer: spaces memory strobes by a settable number of cycles
`timescale 1ns/1ps
`default_nettype none
module ndma_pacer
  import ndma_pkg::*;
#(
  parameter int width = 4
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Pacing control
  input  wire logic             run,
  input  wire logic [width-1:0] period,
  output logic                  tick
);
  // Elaboration check: one bit cannot hold a reload value above one
  if (width < 2) begin : g_width_check
    $error("pacer width too small");
  end

  typedef struct packed {
    logic [width-1:0] count;
    logic             tick;
  } pacer_s;

  pacer_s state;
  pacer_s next_state;

  // Count down from period; tick on reaching one
  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (!run) begin
      next_state.count = period;
    end else if (state.count <= {{(width-1){1'b0}}, 1'b1}) begin
      next_state.tick  = 1'b1;
      next_state.count = period;
    end else begin
      next_state.count = state.count - {{(width-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;
endmodule
`default_nettype wire

// file: verilog/ndma_pkg.sv
// Constants and types shared by the normal-mode copy engine
package ndma_pkg;
  // Register byte addresses on the coprocessor register port
  localparam logic [15:0] dma_control_addr     = 16'h2230;
  localparam logic [15:0] dma_src_addr_lo      = 16'h2232;
  localparam logic [15:0] dma_src_addr_mid     = 16'h2233;
  localparam logic [15:0] dma_src_addr_hi      = 16'h2234;
  localparam logic [15:0] dma_dst_addr_lo      = 16'h2235;
  localparam logic [15:0] dma_dst_addr_mid     = 16'h2236;
  localparam logic [15:0] dma_dst_addr_hi      = 16'h2237;
  localparam logic [15:0] dma_count_lo         = 16'h2238;
  localparam logic [15:0] dma_count_hi         = 16'h2239;
  localparam logic [15:0] coprocessor_flags_addr = 16'h2301;

  // Control register field positions
  localparam int src_sel_lsb       = 0;
  localparam int dest_select_bit   = 2;
  localparam int conv_mode_bit     = 5;
  localparam int bus_priority_bit  = 6;
  localparam int transfer_en_bit   = 7;
  // Flag register position of the completion flag
  localparam int done_flag_bit     = 5;

  // Reset values
  localparam logic [7:0]  control_reset = 8'h00;
  localparam logic [23:0] addr_reset    = 24'h000000;
  localparam logic [15:0] count_reset   = 16'h0000;

  // Memory selectors
  localparam logic [1:0] src_rom  = 2'h0;
  localparam logic [1:0] src_bwr  = 2'h1;
  localparam logic [1:0] src_iram = 2'h2;
  localparam logic       dst_iram = 1'b0;
  localparam logic       dst_bwr  = 1'b1;

  // Address widths per memory
  localparam int rom_addr_bits  = 24;
  localparam int bwr_addr_bits  = 18;
  localparam int iram_addr_bits = 11;

  // Transfer rates: fast 10.74 MHz, slow 5.37 MHz, on a 10.74 MHz base clock
  localparam real clock_mhz     = 10.74;
  localparam real fast_rate_mhz = 10.74;
  localparam real slow_rate_mhz = 5.37;
  localparam int  fast_cycles   = int'(clock_mhz / fast_rate_mhz);
  localparam int  slow_cycles   = int'(clock_mhz / slow_rate_mhz);

  // Engine states
  typedef enum logic [3:0] {
    st_idle  = 4'b0001,
    st_read  = 4'b0010,
    st_write = 4'b0100,
    st_done  = 4'b1000
  } eng_state_e;
endpackage
